// ### src/i2cs_regs.svh
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

// general call address and direction field codes
`define I2CS_GC_ADDR 7'h00
`define I2CS_DIR_INC 2'h0
`define I2CS_DIR_DEC 2'h2
`define I2CS_DIR_FIX 2'h3

// device byte map
`define I2CS_MEM_AW 4
`define I2CS_MEM_BYTES 14'h0010
`define I2CS_HWCTL_OFS 14'h0000
`define I2CS_EVT_OFS 14'h0001
`define I2CS_WDT_LO_OFS 14'h0008
`define I2CS_WDT_HI_OFS 14'h0009
`define I2CS_BYTE_RST 8'h00

// controller registers on the apb side
`define I2CS_APB_CMD 12'h000
`define I2CS_APB_STAT 12'h004
`define I2CS_APB_DIV 12'h008
`define I2CS_CMD_START 8
`define I2CS_CMD_STOP 9
`define I2CS_CMD_WR 10
`define I2CS_CMD_RD 11
`define I2CS_CMD_NACK 12

// quarter bit time of the serial clock, in ns and in clk cycles
`define I2CS_CLK_NS 40
`define I2CS_QTR_NS 400
`define I2CS_DIV_RST 16'((`I2CS_QTR_NS + `I2CS_CLK_NS - 1) / `I2CS_CLK_NS)

`endif

// ### src/i2cs_pkg.sv
`default_nettype none
package i2cs_pkg;
`include "i2cs_regs.svh"

typedef logic [6:0] i2cs_saddr_t;
typedef logic [11:0] i2cs_paddr_t;

typedef enum logic [2:0] {
  D_IDLE = 3'b000,
  D_WAKE = 3'b001,
  D_CTRL = 3'b010,
  D_GC = 3'b011,
  D_RX = 3'b100,
  D_TX = 3'b101
} i2cs_dst_t;

typedef enum logic [1:0] {
  H_IDLE = 2'b00,
  H_START = 2'b01,
  H_BIT = 2'b10,
  H_STOP = 2'b11
} i2cs_hst_t;

typedef struct packed {
  i2cs_dst_t st;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, lock_m, lock_s;
  logic armed, woke, go_tx, ack_en, mult, wbuf_v;
  logic sda_oe, scl_oe, wake_req, pdown;
  logic evt_hold, wdt_hold, wdt_acks;
  logic [3:0] cnt;
  logic [1:0] nb;
  logic [1:0] dir;
  logic [7:0] sh, ahi, wbuf, evt, evt_pend;
  logic [13:0] addr;
  logic [15:0] wdt, wdt_pend, snap;
  logic [15:0][7:0] mem;
} i2cs_dev_t;

typedef struct packed {
  i2cs_hst_t st;
  logic scl_m, scl_s, sda_m, sda_s, rdy_m, rdy_s;
  logic scl_oe, sda_oe, nack, pready, pslverr;
  logic [1:0] q;
  logic [3:0] bits;
  logic [15:0] div, tcnt;
  logic [8:0] sh, rx;
  logic [7:0] rdata;
  logic [31:0] prdata;
} i2cs_host_t;

endpackage
`default_nettype wire

// ### src/i2cs_if.sv
`timescale 1ns/1ps
`default_nettype none
// open-drain wires: a line is low while either end enables its driver
interface i2cs_if;
  logic scl_oe_h;
  logic scl_oe_d;
  logic sda_oe_h;
  logic sda_oe_d;
  logic dev_ready;
  logic scl;
  logic sda;

  // pull-ups give the high level when nobody drives
  assign scl = ~(scl_oe_h | scl_oe_d);
  assign sda = ~(sda_oe_h | sda_oe_d);

  modport dev(input scl, input sda, output scl_oe_d, output sda_oe_d, output dev_ready);
  modport host(input scl, input sda, input dev_ready, output scl_oe_h, output sda_oe_h);
endinterface
`default_nettype wire

// ### src/i2cs_dev.sv
// Behaviour
// - general call with low bit one writes us
// - general call low bit zero: ack, ignore rest; here that byte is nacked, rest ignored
// - before init, never ack, ignore bus
// - after init, wait for first start
// - master reads only after address write
// - master may wait for ready output
// - low power: start wakes, stretch clock
// - wake before address; mismatch powers down
// - matching read control byte acked, else ignore
// - read continues until master nack, stop
// - read address steps unless single byte
// - start/stop during read stops driving
// - write bytes acked and stored
// - write address steps unless single byte
// - start/stop during write halts it
// - partial multi-byte register write discarded
// - master never writes unused addresses
// - each register captured at read start
// - read side effect after capture
// - multi-byte read effect needs full read
// - watchdog count clears as it is read
// - events during read held pending
// - top address bits give step direction
// - two address bytes precede write data
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module i2cs_dev
  import i2cs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic init_done,
  input wire logic low_power,
  input wire logic clk_locked,
  input wire i2cs_pkg::i2cs_saddr_t slave_addr,
  input wire logic [7:0] hw_event,
  input wire logic wdt_tick,
  output logic wake_req,
  output logic power_down,
  output logic [7:0] hardware_control_reg,
  i2cs_if.dev bus
);
  import i2cs_pkg::*;

  i2cs_dev_t s;
  i2cs_dev_t n;
  logic rise;
  logic fall;
  logic sta;
  logic sto;
  logic abort;
  logic [7:0] byte_in;
  logic [13:0] ad;

  // next address for a multi-byte step; reserved code steps up
  function automatic logic [13:0] step(input logic [13:0] a, input logic [1:0] d);
    logic [13:0] r;
    r = a + 14'h0001;
    if (d == `I2CS_DIR_DEC)
      r = a - 14'h0001;
    else if (d == `I2CS_DIR_FIX)
      r = a;
    return r; // wraps at the top of the space
  endfunction

  function automatic logic is_wdt(input logic [13:0] a);
    return (a == `I2CS_WDT_LO_OFS) || (a == `I2CS_WDT_HI_OFS);
  endfunction

  // byte as the master sees it; counter bytes come from the snapshot
  function automatic logic [7:0] rd_byte(input i2cs_dev_t v, input logic [13:0] a);
    logic [7:0] r;
    r = `I2CS_BYTE_RST;
    if (a == `I2CS_EVT_OFS)
      r = v.evt;
    else if (a == `I2CS_WDT_LO_OFS)
      r = v.snap[7:0];
    else if (a == `I2CS_WDT_HI_OFS)
      r = v.snap[15:8];
    else if (a < `I2CS_MEM_BYTES)
      r = v.mem[a[`I2CS_MEM_AW-1:0]];
    return r;
  endfunction

  always_comb
  begin
    n = s;
    n.pdown = 1'b0;
    abort = 1'b0;
    ad = s.addr;
    // pins pass two flops before anything looks at them
    n.scl_m = bus.scl;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = bus.sda;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
    n.lock_m = clk_locked;
    n.lock_s = s.lock_m;
    rise = s.scl_s & ~s.scl_d;
    fall = ~s.scl_s & s.scl_d;
    sta = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
    sto = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
    byte_in = {s.sh[6:0], s.sda_s};

    // hardware events go aside while a read holds the register
    if (s.evt_hold)
      n.evt_pend = s.evt_pend | hw_event;
    else
      n.evt = s.evt | hw_event;
    if (wdt_tick & s.wdt_hold)
      n.wdt_pend = s.wdt_pend + 16'h0001;
    else if (wdt_tick)
      n.wdt = s.wdt + 16'h0001;

    if (!init_done)
    begin
      // not yet initialised: deaf and silent
      n.st = D_IDLE;
      n.armed = 1'b0;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      n.wake_req = 1'b0;
      n.woke = 1'b0;
      abort = 1'b1;
    end
    else if (sta | sto)
    begin
      // any start or stop ends what was going on
      abort = 1'b1;
      n.sda_oe = 1'b0;
      n.cnt = 4'h0;
      n.go_tx = 1'b0;
      n.wbuf_v = 1'b0;
      n.armed = s.armed | sta;
      if (sto)
        n.st = D_IDLE;
      else if (low_power)
      begin
        n.st = D_WAKE;
        n.scl_oe = 1'b1;
        n.wake_req = 1'b1;
      end
      else
        n.st = D_CTRL;
    end
    else
    begin
      unique case (s.st)
        D_IDLE:
          n.sda_oe = 1'b0; // nothing acked until next start
        D_WAKE:
          if (s.lock_s)
          begin
            n.scl_oe = 1'b0; // release once clocks are locked
            n.wake_req = 1'b0;
            n.woke = 1'b1;
            n.st = D_CTRL;
          end
        D_CTRL, D_GC, D_RX:
          if (rise && s.cnt < 4'h8)
          begin
            n.sh = byte_in;
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'h7)
            begin
              n.ack_en = 1'b1;
              if (s.st == D_CTRL)
              begin
                if (byte_in[7:1] == slave_addr)
                begin
                  n.go_tx = byte_in[0];
                  n.st = byte_in[0] ? D_CTRL : D_RX;
                  n.nb = byte_in[0] ? 2'h2 : 2'h0;
                  n.mult = 1'b0;
                  n.woke = 1'b0;
                end
                else if (byte_in == {`I2CS_GC_ADDR, 1'b0})
                  n.st = D_GC;
                else
                begin
                  n.st = D_IDLE;
                  n.ack_en = 1'b0;
                  n.pdown = s.woke;
                  n.woke = 1'b0;
                end
              end
              else if (s.st == D_GC)
              begin
                n.st = byte_in[0] ? D_RX : D_IDLE;
                n.ack_en = byte_in[0];
                n.nb = 2'h0;
                n.mult = 1'b0;
              end
              else if (s.nb == 2'h0)
                n.ahi = byte_in;
              else if (s.nb == 2'h1)
              begin
                n.addr = {s.ahi[5:0], byte_in};
                n.dir = s.ahi[7:6];
              end
              else
              begin
                // the first byte's step is taken once a second one shows up
                if (s.nb == 2'h3 && !s.mult)
                begin
                  ad = step(ad, s.dir);
                  n.mult = 1'b1;
                end
                if (ad == `I2CS_WDT_LO_OFS)
                begin
                  n.wbuf = byte_in; // held until the high byte
                  n.wbuf_v = 1'b1;
                end
                else if (ad == `I2CS_WDT_HI_OFS)
                begin
                  if (s.wbuf_v)
                    n.wdt = {byte_in, s.wbuf};
                  n.wbuf_v = 1'b0;
                end
                else if (ad != `I2CS_EVT_OFS && ad < `I2CS_MEM_BYTES)
                  n.mem[ad[`I2CS_MEM_AW-1:0]] = byte_in;
                if (s.nb == 2'h3)
                  ad = step(ad, s.dir);
                n.addr = ad;
              end
              if (s.st == D_RX)
                n.nb = (s.nb == 2'h3) ? 2'h3 : s.nb + 2'h1;
            end
          end
          else if (fall && s.cnt == 4'h8)
          begin
            n.sda_oe = s.ack_en;
            n.cnt = 4'h9;
          end
          else if (fall && s.cnt == 4'h9)
          begin
            n.cnt = s.go_tx ? 4'hA : 4'h0;
            n.st = s.go_tx ? D_TX : s.st;
            n.go_tx = 1'b0;
            n.sda_oe = s.go_tx; // keep the line low until the first bit is loaded
          end
        D_TX:
          if (s.cnt == 4'hA)
          begin
            // load the next byte, capturing it as it is taken
            if (s.nb == 2'h3 && !s.mult)
            begin
              ad = step(ad, s.dir);
              n.mult = 1'b1;
            end
            n.addr = ad;
            if (is_wdt(ad) && !s.wdt_hold)
            begin
              n.snap = n.wdt;
              n.wdt_hold = 1'b1;
              n.wdt_acks = 1'b0;
            end
            else if (!is_wdt(ad) && s.wdt_hold)
            begin
              n.wdt = n.wdt + n.wdt_pend; // left part way, no clear
              n.wdt_pend = 16'h0000;
              n.wdt_hold = 1'b0;
            end
            if (ad == `I2CS_EVT_OFS)
              n.evt_hold = 1'b1;
            n.sh = rd_byte(n, ad);
            n.sda_oe = ~n.sh[7];
            n.cnt = 4'h0;
          end
          else if (rise && s.cnt < 4'h8)
          begin
            n.cnt = s.cnt + 4'h1;
            n.sh = {s.sh[6:0], 1'b0};
          end
          else if (rise)
          begin
            // ack slot: the byte was read, so its side effect fires now; the watchdog clear waits for the second byte's ack slot, acked or nacked
            if (s.addr == `I2CS_EVT_OFS && s.evt_hold)
            begin
              n.evt = n.evt_pend;
              n.evt_pend = 8'h00;
              n.evt_hold = 1'b0;
            end
            if (is_wdt(s.addr) && s.wdt_hold)
            begin
              n.wdt_acks = 1'b1;
              if (s.wdt_acks)
              begin
                n.wdt = n.wdt_pend;
                n.wdt_pend = 16'h0000;
                n.wdt_hold = 1'b0;
                n.wdt_acks = 1'b0;
              end
            end
            if (s.nb == 2'h3)
              n.addr = step(s.addr, s.dir);
            n.nb = 2'h3;
            n.cnt = 4'h9;
            if (s.sda_s)
            begin
              n.st = D_IDLE; // master nack ends the read
              abort = 1'b1;
            end
          end
          else if (fall && s.cnt == 4'h9)
            n.cnt = 4'hA;
          else if (fall && s.cnt == 4'h8)
            n.sda_oe = 1'b0;
          else if (fall)
            n.sda_oe = ~s.sh[7];
        default:
          n.st = D_IDLE;
      endcase
    end

    // an interrupted read drops its effect and keeps every held event
    if (abort & n.evt_hold)
    begin
      n.evt = n.evt | n.evt_pend;
      n.evt_pend = 8'h00;
      n.evt_hold = 1'b0;
    end
    if (abort & n.wdt_hold)
    begin
      n.wdt = n.wdt + n.wdt_pend;
      n.wdt_pend = 16'h0000;
      n.wdt_hold = 1'b0;
      n.wdt_acks = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.st <= D_IDLE;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_d <= 1'b1;
    end
    else
      s <= n;
  end

  // all outputs straight from the state flops
  assign bus.sda_oe_d = s.sda_oe;
  assign bus.scl_oe_d = s.scl_oe;
  assign bus.dev_ready = s.armed;
  assign wake_req = s.wake_req;
  assign power_down = s.pdown;
  assign hardware_control_reg = s.mem[0];
endmodule // i2cs_dev
`default_nettype wire

// ### src/i2cs_host.sv
`timescale 1ns/1ps
`default_nettype none
module i2cs_host
  import i2cs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire i2cs_pkg::i2cs_paddr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  i2cs_if.host bus
);
  import i2cs_pkg::*;

  i2cs_host_t s;
  i2cs_host_t n;
  logic tick;
  logic adv;
  logic mapped;

  always_comb
  begin
    n = s;
    tick = 1'b0;
    n.scl_m = bus.scl;
    n.scl_s = s.scl_m;
    n.sda_m = bus.sda;
    n.sda_s = s.sda_m;
    n.rdy_m = bus.dev_ready; // ready may replace probing
    n.rdy_s = s.rdy_m;
    mapped = (paddr == `I2CS_APB_CMD) || (paddr == `I2CS_APB_STAT) || (paddr == `I2CS_APB_DIV);

    // one wait state: ready and read data both leave flops
    n.pready = 1'b0;
    if (psel & penable & ~s.pready)
    begin
      n.pready = 1'b1;
      n.pslverr = ~mapped;
      n.prdata = 32'h0000_0000;
      if (paddr == `I2CS_APB_STAT)
        n.prdata = {16'h0000, s.rdata, 5'h00, s.rdy_s, s.nack, s.st != H_IDLE};
      else if (paddr == `I2CS_APB_DIV)
        n.prdata = {16'h0000, s.div};
    end
    if (psel & penable & s.pready & pwrite)
    begin
      if (paddr == `I2CS_APB_DIV)
        n.div = pwdata[15:0];
      else if (paddr == `I2CS_APB_CMD && s.st == H_IDLE)
      begin
        // one bus operation per command; software orders them
        n.q = 2'h0;
        n.bits = 4'h0;
        n.tcnt = s.div;
        if (pwdata[`I2CS_CMD_START])
          n.st = H_START;
        else if (pwdata[`I2CS_CMD_STOP])
          n.st = H_STOP;
        else if (pwdata[`I2CS_CMD_WR])
        begin
          n.st = H_BIT;
          n.sh = {pwdata[7:0], 1'b1};
        end
        else if (pwdata[`I2CS_CMD_RD])
        begin
          n.st = H_BIT;
          n.sh = {8'hFF, pwdata[`I2CS_CMD_NACK]}; // nack the last byte
        end
      end
    end

    // quarter-bit divider runs only while an operation is active
    if (s.st != H_IDLE)
    begin
      if (s.tcnt == 16'h0000)
      begin
        tick = 1'b1;
        n.tcnt = s.div - 16'h0001;
      end
      else
        n.tcnt = s.tcnt - 16'h0001;
    end

    // quarter two waits for scl high, so a stretching slave holds us
    adv = !(s.q == 2'h2 && !s.scl_s);
    if (tick)
    begin
      unique case (s.st)
        H_IDLE:
          n.q = s.q;
        H_START:
          if (s.q == 2'h0)
            n.sda_oe = 1'b0;
          else if (s.q == 2'h1)
            n.scl_oe = 1'b0;
          else if (s.q == 2'h2 && adv)
            n.sda_oe = 1'b1;
          else if (s.q == 2'h3)
          begin
            n.scl_oe = 1'b1;
            n.st = H_IDLE;
          end
        H_STOP:
          if (s.q == 2'h0)
            n.sda_oe = 1'b1;
          else if (s.q == 2'h1)
            n.scl_oe = 1'b0;
          else if (s.q == 2'h3)
          begin
            n.sda_oe = 1'b0;
            n.st = H_IDLE;
          end
        H_BIT:
          if (s.q == 2'h0)
            n.sda_oe = ~s.sh[8];
          else if (s.q == 2'h1)
            n.scl_oe = 1'b0;
          else if (s.q == 2'h2 && adv)
            n.rx = {s.rx[7:0], s.sda_s};
          else if (s.q == 2'h3)
          begin
            n.scl_oe = 1'b1;
            n.sh = {s.sh[7:0], 1'b1};
            n.bits = s.bits + 4'h1;
            if (s.bits == 4'h8)
            begin
              n.st = H_IDLE;
              n.nack = s.rx[0];
              n.rdata = s.rx[8:1];
              n.sda_oe = 1'b0;
            end
          end
      endcase
      if (adv)
        n.q = s.q + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.st <= H_IDLE;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.div <= `I2CS_DIV_RST;
    end
    else
      s <= n;
  end

  assign bus.scl_oe_h = s.scl_oe;
  assign bus.sda_oe_h = s.sda_oe;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
endmodule // i2cs_host
`default_nettype wire

// ### verification/i2cs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// wire-side watch of the device end of the link
module i2cs_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic scl_oe_d,
  input wire logic sda_oe_d,
  input wire logic dev_ready,
  input wire logic init_done,
  input wire logic low_power,
  input wire logic clk_locked,
  input wire logic wake_req,
  input wire logic power_down
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // a stretch in progress, then a lock long enough to pass the synchroniser
  sequence s_stretch;
    scl_oe_d && wake_req;
  endsequence
  sequence s_locked;
    clk_locked [*4];
  endsequence
  AST_STRETCH_END: assert property (s_stretch ##0 s_locked |-> ##[0:4] !scl_oe_d)
    else $error("clock stretch outlived the lock");
  AST_STRETCH_ONLY_WAKE: assert property (scl_oe_d |-> wake_req || $past(wake_req))
    else $error("device held the clock without a wake");
  AST_WAKE_NEEDS_LP: assert property ($rose(wake_req) |-> low_power)
    else $error("wake outside low power");
  AST_PDOWN_PULSE: assert property (power_down |=> !power_down && !wake_req)
    else $error("power down not a single pulse");
  AST_PDOWN_LP: assert property (power_down |-> low_power)
    else $error("power down outside low power");
  AST_MUTE_BEFORE_INIT: assert property (!init_done && !$past(init_done) |-> !sda_oe_d && !scl_oe_d)
    else $error("device drove the link before init");
  AST_READY_DROPS: assert property (!init_done |-> ##[1:3] !dev_ready)
    else $error("ready stayed up without init");
  AST_READY_NEEDS_INIT: assert property ($rose(dev_ready) |-> init_done && $past(init_done))
    else $error("ready rose before init");
  AST_ACK_NEEDS_READY: assert property (sda_oe_d |-> dev_ready)
    else $error("device drove data while not ready");
  AST_DRIVE_ON_LOW_CLK: assert property ($rose(sda_oe_d) |-> !$past(scl))
    else $error("device took the data line while the clock was high");
  // the wake path is the rarest branch, so make its visit visible
  cov_stretch: cover property (s_stretch ##0 s_locked);
endmodule // i2cs_chk
`default_nettype wire

// ### verification/i2c_slave_register_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_regs.svh"
module i2c_slave_register_access_tb;
  import i2cs_pkg::*;
  localparam i2cs_saddr_t SA = 7'h2A; // strap address of the device
  localparam logic [31:0] WR = 32'h1 << `I2CS_CMD_WR;
  localparam logic [31:0] RD = 32'h1 << `I2CS_CMD_RD;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  i2cs_paddr_t paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic init_done = 1'b0;
  logic low_power = 1'b0;
  logic clk_locked = 1'b1;
  logic [7:0] hw_event = 8'h00;
  logic wdt_tick = 1'b0;
  logic wake_req;
  logic power_down;
  logic [7:0] hardware_control_reg;
  logic [31:0] stat;
  logic [31:0] rd;
  logic perr;
  int num_errors = 0;
  int compares = 0;
  int pd_cnt = 0;

  i2cs_if i_i2cs_if();
  i2cs_host i_i2cs_host (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(i_i2cs_if));
  i2cs_dev i_i2cs_dev (.clk(clk), .srst(srst), .init_done(init_done), .low_power(low_power),
    .clk_locked(clk_locked), .slave_addr(SA), .hw_event(hw_event), .wdt_tick(wdt_tick), .wake_req(wake_req),
    .power_down(power_down), .hardware_control_reg(hardware_control_reg), .bus(i_i2cs_if));
  i2cs_chk i_i2cs_chk (.clk(clk), .srst(srst), .scl(i_i2cs_if.scl), .scl_oe_d(i_i2cs_if.scl_oe_d),
    .sda_oe_d(i_i2cs_if.sda_oe_d), .dev_ready(i_i2cs_if.dev_ready), .init_done(init_done),
    .low_power(low_power), .clk_locked(clk_locked), .wake_req(wake_req), .power_down(power_down));

  // 25 MHz system clock
  always #20 clk = ~clk;

  // count power-down pulses so a missing or doubled one shows
  always @(posedge clk)
    if (power_down === 1'b1)
      pd_cnt <= pd_cnt + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the idle cycle at the end keeps psel from being driven twice in a step
  task automatic apb(input logic we, input i2cs_paddr_t a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // issue one link command and poll until the controller is idle again
  task automatic op(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, `I2CS_APB_CMD, c, stat);
    stat = 32'h1;
    while (stat[0] !== 1'b0 && n < 4000)
    begin
      apb(1'b0, `I2CS_APB_STAT, 32'h0, stat);
      n++;
    end
    // a controller that never goes idle again is a failure, not a silent skip
    if (n >= 4000)
      num_errors++;
  endtask

  task automatic sta;
    op(32'h1 << `I2CS_CMD_START);
  endtask

  task automatic sto;
    op(32'h1 << `I2CS_CMD_STOP);
  endtask

  task automatic wb(input logic [7:0] d, input logic nk);
    op(WR | {24'h0, d});
    chk({31'h0, stat[1]}, {31'h0, nk});
  endtask

  task automatic rb(input logic [7:0] exp, input logic nk);
    op(RD | {19'h0, nk, 12'h0});
    chk({24'h0, stat[15:8]}, {24'h0, exp});
  endtask

  task automatic setaddr(input logic [7:0] hi, input logic [7:0] lo);
    sta();
    wb({SA, 1'b0}, 1'b0);
    wb(hi, 1'b0);
    wb(lo, 1'b0);
  endtask

  task automatic rd_open;
    sta();
    wb({SA, 1'b1}, 1'b0);
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      wdt_tick <= 1'b1;
      @(posedge clk);
      wdt_tick <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // generous bound: the whole sequence needs well under half of it
  initial
  begin
    #(90000 * 40);
    num_errors++;
    close_out();
  end

  initial
  begin
    int i;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `I2CS_APB_DIV, 32'h0, rd);
    chk(rd, {16'h0, `I2CS_DIV_RST});
    apb(1'b1, `I2CS_APB_DIV, 32'h8, rd);
    apb(1'b0, `I2CS_APB_DIV, 32'h0, rd);
    chk(rd, 32'h8);
    apb(1'b0, 12'h00C, 32'h0, rd);
    chk({31'h0, perr}, 32'h1);
    $display("test apb: done");
    // silent before init, and still waiting for a start after it
    sta();
    wb({SA, 1'b0}, 1'b1);
    wb(8'h00, 1'b1);
    sto();
    init_done <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, i_i2cs_if.dev_ready}, 32'h0);
    setaddr(8'h00, 8'h07);
    apb(1'b0, `I2CS_APB_STAT, 32'h0, rd);
    chk({31'h0, rd[2]}, 32'h1);
    wb(8'h77, 1'b0);
    rd_open();
    rb(8'h77, 1'b1);
    sto();
    $display("test init: done");
    // single write, multi write with increment, then stepping on reads
    setaddr(8'h00, 8'h00);
    wb(8'hA5, 1'b0);
    sto();
    chk({24'h0, hardware_control_reg}, 32'h0000_00A5);
    setaddr(8'h00, 8'h02);
    for (i = 0; i < 5; i++)
      wb(8'(8'h11 * (i + 1)), 1'b0);
    sto();
    rd_open();
    rb(8'h77, 1'b1);
    setaddr(8'h80, 8'h04);
    sto();
    rd_open();
    rb(8'h33, 1'b0);
    rb(8'h22, 1'b0);
    rb(8'h11, 1'b1);
    setaddr(8'h3F, 8'hFF);
    rd_open();
    rb(8'h00, 1'b0);
    rb(8'hA5, 1'b0);
    rb(8'h00, 1'b1);
    rd_open();
    rb(8'h11, 1'b1);
    setaddr(8'hC0, 8'h05);
    rd_open();
    for (i = 0; i < 3; i++)
      rb(8'h44, i == 2);
    rd_open();
    rb(8'h44, 1'b1);
    setaddr(8'h40, 8'h02); // reserved code steps up
    rd_open();
    rb(8'h11, 1'b0);
    rb(8'h22, 1'b1);
    sto();
    $display("test address: done");
    // watchdog count: partial write, snapshot, partial read, pending ticks
    tick(3);
    setaddr(8'h00, 8'h08);
    wb(8'h77, 1'b0);
    sto();
    rd_open();
    rb(8'h03, 1'b0);
    tick(1);
    rb(8'h00, 1'b1);
    sto();
    setaddr(8'h00, 8'h08);
    rd_open();
    rb(8'h01, 1'b1);
    rd_open();
    rb(8'h01, 1'b0);
    rb(8'h00, 1'b1);
    setaddr(8'h00, 8'h08);
    rd_open();
    rb(8'h00, 1'b0);
    rb(8'h00, 1'b1);
    // a complete low-then-high write lands as one value
    setaddr(8'h00, 8'h08);
    wb(8'h34, 1'b0);
    wb(8'h12, 1'b0);
    setaddr(8'h00, 8'h08);
    rd_open();
    rb(8'h34, 1'b0);
    rb(8'h12, 1'b1);
    // event byte clears on read and returns the old value
    hw_event <= 8'h05;
    @(posedge clk);
    hw_event <= 8'h00;
    setaddr(8'h00, 8'h01);
    rd_open();
    rb(8'h05, 1'b1);
    rd_open();
    rb(8'h00, 1'b1);
    sto();
    $display("test side effects: done");
    // general call, both low-bit cases, and a foreign address
    sta();
    wb(8'h00, 1'b0);
    wb(8'h04, 1'b1);
    wb(8'h00, 1'b1);
    sto();
    sta();
    wb(8'h00, 1'b0);
    wb(8'h01, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h3C, 1'b0);
    sto();
    chk({24'h0, hardware_control_reg}, 32'h0000_003C);
    rd_open();
    rb(8'h3C, 1'b1);
    sto();
    sta();
    wb({SA ^ 7'h01, 1'b1}, 1'b1);
    sto();
    $display("test general call: done");
    // low power: a start wakes and stretches, a foreign address powers down
    low_power <= 1'b1;
    clk_locked <= 1'b0;
    sta();
    chk({31'h0, wake_req}, 32'h1);
    chk({31'h0, i_i2cs_if.scl_oe_d}, 32'h1);
    clk_locked <= 1'b1;
    wb({SA ^ 7'h01, 1'b0}, 1'b1);
    sto();
    chk(pd_cnt, 32'h1);
    low_power <= 1'b0;
    $display("test wake: done");
    close_out();
  end
endmodule // i2c_slave_register_access_tb
`default_nettype wire
